// ---- src/fsss_slave_state_sequencer.sv ----
// How it works
// - State changes only on master request
// - Reset enters power-on, no traffic allowed
// - Power-on to config checks mailbox setup
// - Config allows mailbox, refuses process data
// - Config to guarded checks process setup, and clock setup if DC_USED
// - Inputs copied to memory before acknowledge
// - Guarded: traffic allowed, inputs refresh, outputs safe
// - WDT_MON_EN low lets guarded drive outputs
// - Running applies master outputs, all traffic
// - Firmware update only from power-on
// - Firmware update: file transfer mailbox only
// - Timeout restarts on access, forces outputs
// - Tick is multiplier plus two base periods
`timescale 1ns/1ns
`default_nettype none
module fsss_slave_state_sequencer
   import fsss_pkg::*;
(
   // Clock and reset
   input  wire logic                  REF_CLK,
   input  wire logic                  RST_B,
   // State requests from the master
   input  wire logic                  REQ_VALID,
   input  wire fsss_pkg::fsss_state_t REQ_STATE,
   input  wire logic                  ERR_CLEAR,
   // Channel checks
   input  wire logic                  MBX_SETUP_OK,
   input  wire logic                  PD_SETUP_OK,
   input  wire logic                  CLK_SETUP_OK,
   input  wire logic                  DC_USED,
   // Traffic
   input  wire logic                  MBX_MSG,
   input  wire logic                  MBX_IS_FILE,
   input  wire logic                  PD_ACCESS,
   input  wire logic [fsss_pkg::FSSS_IO_W-1:0]   RX_OUT_DATA,
   // Local process inputs (pins)
   input  wire logic [fsss_pkg::FSSS_IO_W-1:0]   PIN_IN,
   // Timeout configuration
   input  wire logic                  WDT_MON_EN,
   input  wire logic [fsss_pkg::FSSS_MULT_W-1:0] WDT_MULT,
   input  wire logic [fsss_pkg::FSSS_WDT_W-1:0]  WDT_TIME,
   // Results
   output logic                       REQ_ACK,
   output logic                       REQ_ERR,
   output fsss_pkg::fsss_state_t      STATE,
   output logic                       MBX_ACCEPT,
   output logic                       MBX_REJECT,
   output logic                       PD_ACCEPT,
   output logic                       PD_REJECT,
   output logic [fsss_pkg::FSSS_IO_W-1:0]        DPM_IN,
   output logic [fsss_pkg::FSSS_IO_W-1:0]        PIN_OUT,
   output logic                       WDT_EXPIRED
);
   import fsss_pkg::*;

   typedef struct packed {
      fsss_state_t          state;
      logic                 ack;
      logic                 err;
      logic [FSSS_IO_W-1:0] in_s1;
      logic [FSSS_IO_W-1:0] in_s2;
      logic [FSSS_IO_W-1:0] dpm_in;
      logic [FSSS_IO_W-1:0] out;
      logic [2:0]           base_cnt;
      logic [16:0]          mult_cnt;
      logic [FSSS_WDT_W-1:0] wdt_cnt;
      logic                 expired;
   } fsss_regs_t;

   fsss_regs_t r_reg;
   fsss_regs_t r_next;

   function automatic logic pd_allowed(input fsss_state_t s);
      pd_allowed = (s == FSSS_GUARDED) || (s == FSSS_RUNNING);
   endfunction

   logic wdt_on;
   logic tick;
   logic step_ok;
   logic pd_ok;

   assign wdt_on = WDT_MON_EN && (WDT_TIME != '0);
   assign tick   = (r_reg.base_cnt == FSSS_BASE_LAST) &&
                   (r_reg.mult_cnt >= ({1'b0, WDT_MULT} + FSSS_MULT_ADD
                                       - 17'h00001));
   assign pd_ok  = PD_ACCESS && pd_allowed(r_reg.state);

   // ----------------------------------------
   // Transition check
   // ----------------------------------------
   always_comb begin
      step_ok = 1'b0;
      case (REQ_STATE)
         FSSS_POWER_ON: step_ok = 1'b1;
         FSSS_CONFIG: begin
            step_ok = (r_reg.state == FSSS_POWER_ON) ? MBX_SETUP_OK :
                      (r_reg.state != FSSS_FW_UPD);
         end
         FSSS_GUARDED: begin
            step_ok = ((r_reg.state == FSSS_CONFIG) &&
                       PD_SETUP_OK && (!DC_USED || CLK_SETUP_OK)) ||
                      (r_reg.state == FSSS_RUNNING);
         end
         FSSS_RUNNING: step_ok = (r_reg.state == FSSS_GUARDED);
         FSSS_FW_UPD:  step_ok = (r_reg.state == FSSS_POWER_ON);
         default:      step_ok = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      r_next       = r_reg;
      r_next.ack   = 1'b0;
      r_next.in_s1 = PIN_IN;
      r_next.in_s2 = r_reg.in_s1;
      if (ERR_CLEAR) begin
         r_next.err = 1'b0;
      end
      if (REQ_VALID) begin
         if (step_ok) begin
            r_next.state = REQ_STATE;
            r_next.ack   = 1'b1;
            if (REQ_STATE == FSSS_GUARDED) begin
               r_next.dpm_in = r_reg.in_s2;
            end
         end else begin
            r_next.err = 1'b1;
         end
      end
      if (pd_allowed(r_reg.state)) begin
         r_next.dpm_in = r_reg.in_s2;
      end
      // Timeout timebase
      if (!wdt_on || pd_ok) begin
         r_next.base_cnt = '0;
         r_next.mult_cnt = '0;
         r_next.wdt_cnt  = '0;
         r_next.expired  = 1'b0;
      end else if (!r_reg.expired) begin
         r_next.base_cnt = (r_reg.base_cnt == FSSS_BASE_LAST) ? 3'h0 :
                           3'(r_reg.base_cnt + 3'h1);
         if (r_reg.base_cnt == FSSS_BASE_LAST) begin
            r_next.mult_cnt = tick ? 17'h00000 :
                              17'(r_reg.mult_cnt + 17'h00001);
         end
         if (tick) begin
            r_next.wdt_cnt = FSSS_WDT_W'(r_reg.wdt_cnt + 1'b1);
            if (FSSS_WDT_W'(r_reg.wdt_cnt + 1'b1) == WDT_TIME) begin
               r_next.expired = 1'b1;
            end
         end
      end
      // Output stage
      if (r_reg.expired) begin
         r_next.out = FSSS_SAFE_OUT;
      end else if (r_reg.state == FSSS_RUNNING) begin
         r_next.out = RX_OUT_DATA;
      end else if (r_reg.state == FSSS_GUARDED && !WDT_MON_EN) begin
         r_next.out = RX_OUT_DATA;
      end else begin
         r_next.out = FSSS_SAFE_OUT;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         r_reg       <= '0;
         r_reg.state <= FSSS_POWER_ON;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // Traffic gating
   // ----------------------------------------
   always_comb begin
      case (r_reg.state)
         FSSS_POWER_ON: MBX_ACCEPT = 1'b0;
         FSSS_FW_UPD:   MBX_ACCEPT = MBX_MSG && MBX_IS_FILE;
         default:       MBX_ACCEPT = MBX_MSG;
      endcase
   end
   assign MBX_REJECT  = MBX_MSG && !MBX_ACCEPT;
   assign PD_ACCEPT   = pd_ok;
   assign PD_REJECT   = PD_ACCESS && !pd_ok;
   assign REQ_ACK     = r_reg.ack;
   assign REQ_ERR     = r_reg.err;
   assign STATE       = r_reg.state;
   assign DPM_IN      = r_reg.dpm_in;
   assign PIN_OUT     = r_reg.out;
   assign WDT_EXPIRED = r_reg.expired;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_no_self_move;
      @(posedge REF_CLK) disable iff (!RST_B)
      !$past(REQ_VALID) |-> $stable(r_reg.state);
   endproperty
   a_no_self_move: assert property (p_no_self_move)
      else $error("State moved without request");

   property p_fw_only_from_on;
      @(posedge REF_CLK) disable iff (!RST_B)
      (r_reg.state == FSSS_FW_UPD) && ($past(r_reg.state) != FSSS_FW_UPD)
      |-> $past(r_reg.state) == FSSS_POWER_ON;
   endproperty
   a_fw_only_from_on: assert property (p_fw_only_from_on)
      else $error("Firmware update entered from wrong state");

   property p_refuse_err;
      @(posedge REF_CLK) disable iff (!RST_B)
      REQ_VALID && !step_ok |=> REQ_ERR && $stable(r_reg.state);
   endproperty
   a_refuse_err: assert property (p_refuse_err)
      else $error("Refused request did not flag error");

   property p_pd_blocked;
      @(posedge REF_CLK) disable iff (!RST_B)
      (r_reg.state inside {FSSS_POWER_ON, FSSS_CONFIG, FSSS_FW_UPD})
      |-> !PD_ACCEPT;
   endproperty
   a_pd_blocked: assert property (p_pd_blocked)
      else $error("Process data accepted in blocked state");

   property p_fw_mbx;
      @(posedge REF_CLK) disable iff (!RST_B)
      (r_reg.state == FSSS_FW_UPD) && MBX_MSG && !MBX_IS_FILE
      |-> MBX_REJECT;
   endproperty
   a_fw_mbx: assert property (p_fw_mbx)
      else $error("Non file mailbox accepted in update");

   property p_guard_safe;
      @(posedge REF_CLK) disable iff (!RST_B)
      (r_reg.state == FSSS_GUARDED) && WDT_MON_EN ##1
      $past(r_reg.state) == FSSS_GUARDED |-> PIN_OUT == FSSS_SAFE_OUT;
   endproperty
   a_guard_safe: assert property (p_guard_safe)
      else $error("Outputs not safe in guarded state");

   property p_run_apply;
      @(posedge REF_CLK) disable iff (!RST_B)
      (r_reg.state == FSSS_RUNNING) && !r_reg.expired
      |=> PIN_OUT == $past(RX_OUT_DATA);
   endproperty
   a_run_apply: assert property (p_run_apply)
      else $error("Running state did not apply outputs");

   property p_expire_off;
      @(posedge REF_CLK) disable iff (!RST_B)
      r_reg.expired |=> PIN_OUT == FSSS_SAFE_OUT;
   endproperty
   a_expire_off: assert property (p_expire_off)
      else $error("Outputs not forced after timeout");

   property p_cfg_check;
      @(posedge REF_CLK) disable iff (!RST_B)
      REQ_VALID && (r_reg.state == FSSS_POWER_ON) &&
      (REQ_STATE == FSSS_CONFIG) && !MBX_SETUP_OK
      |=> r_reg.state == FSSS_POWER_ON;
   endproperty
   a_cfg_check: assert property (p_cfg_check)
      else $error("Config entered with bad mailbox setup");

   property p_guard_image;
      @(posedge REF_CLK) disable iff (!RST_B)
      REQ_VALID && step_ok && (REQ_STATE == FSSS_GUARDED)
      |=> REQ_ACK && (DPM_IN == $past(r_reg.in_s2));
   endproperty
   a_guard_image: assert property (p_guard_image)
      else $error("Input image not loaded before acknowledge");
endmodule
`default_nettype wire

// ---- src/fsss_pkg.sv ----
package fsss_pkg;
   // ----------------------------------------
   // State codes, readable by the master
   // ----------------------------------------
   typedef enum logic [2:0] {
      FSSS_POWER_ON = 3'b000,
      FSSS_CONFIG   = 3'b001,
      FSSS_GUARDED  = 3'b010,
      FSSS_RUNNING  = 3'b011,
      FSSS_FW_UPD   = 3'b100
   } fsss_state_t;

   // ----------------------------------------
   // Widths and timing
   // ----------------------------------------
   localparam int          FSSS_IO_W       = 8;
   localparam int          FSSS_MULT_W     = 16;
   localparam int          FSSS_WDT_W      = 16;
   localparam int          FSSS_BASE_NS    = 40;
   localparam int          FSSS_CLK_NS     = 8;
   localparam int          FSSS_BASE_CYC   = (FSSS_BASE_NS + FSSS_CLK_NS - 1)
                                             / FSSS_CLK_NS;
   localparam logic [2:0]  FSSS_BASE_LAST  = 3'(FSSS_BASE_CYC - 1);
   localparam logic [16:0] FSSS_MULT_ADD   = 17'h00002;
   localparam logic [FSSS_IO_W-1:0] FSSS_SAFE_OUT = 8'h00;
endpackage

// ---- verification/fsss_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module fsss_master_model (
   // Clock
   input  wire logic             clk,
   // Request, setup and output data
   output logic                  req_valid,
   output fsss_pkg::fsss_state_t req_state,
   output logic                  mbx_ok,
   output logic                  pd_ok,
   output logic                  clk_ok,
   output logic [7:0]            out_data
);
   import fsss_pkg::*;
   initial begin
      req_valid = 1'b0;
      req_state = FSSS_POWER_ON;
      mbx_ok    = 1'b0;
      pd_ok     = 1'b0;
      clk_ok    = 1'b0;
      out_data  = 8'h00;
   end
   // Code is scrambled once released
   task automatic request(input fsss_state_t s);
      @(posedge clk);
      req_valid <= 1'b1;
      req_state <= s;
      @(posedge clk);
      req_valid <= 1'b0;
      req_state <= fsss_state_t'(~s);
   endtask
   task automatic setup(input logic m, input logic p, input logic c);
      @(posedge clk);
      mbx_ok <= m;
      pd_ok  <= p;
      clk_ok <= c;
   endtask
   task automatic send(input logic [7:0] d);
      @(posedge clk);
      out_data <= d;
   endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define FSSS_CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
 err_count++; $display("Error %s exp %h got %h", nm, ex, got); end end
module tb;
   import fsss_pkg::*;
   logic clk = 0, rst_b = 0, err_clr = 0, dc = 0, mbx_msg = 1, mbx_file = 0;
   logic pd_acc = 1, mon_en = 1;
   logic [7:0]  pin_in = 8'h5a;
   logic [15:0] mult = 16'h0000, wtime = 16'h0064;
   wire logic rv, mok, pok, cok, ack, err, ma, mr, pa, pr, wexp;
   wire logic [7:0] rx, dpm, pout;
   wire fsss_state_t rs, st;
   int err_count = 0, n_tests = 0;
   initial forever #4 clk = ~clk;
   fsss_master_model i_m (.clk(clk), .req_valid(rv), .req_state(rs),
      .mbx_ok(mok), .pd_ok(pok), .clk_ok(cok), .out_data(rx));
   fsss_slave_state_sequencer i_dut (.REF_CLK(clk), .RST_B(rst_b),
      .REQ_VALID(rv), .REQ_STATE(rs), .ERR_CLEAR(err_clr),
      .MBX_SETUP_OK(mok), .PD_SETUP_OK(pok), .CLK_SETUP_OK(cok),
      .DC_USED(dc), .MBX_MSG(mbx_msg), .MBX_IS_FILE(mbx_file),
      .PD_ACCESS(pd_acc), .RX_OUT_DATA(rx), .PIN_IN(pin_in),
      .WDT_MON_EN(mon_en), .WDT_MULT(mult), .WDT_TIME(wtime),
      .REQ_ACK(ack), .REQ_ERR(err), .STATE(st), .MBX_ACCEPT(ma),
      .MBX_REJECT(mr), .PD_ACCEPT(pa), .PD_REJECT(pr), .DPM_IN(dpm),
      .PIN_OUT(pout), .WDT_EXPIRED(wexp));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic req(input fsss_state_t s);
      i_m.request(s);
      #1;
   endtask
   task automatic clear_err;
      @(posedge clk) err_clr <= 1'b1;
      @(posedge clk) err_clr <= 1'b0;
      step(1);
      `FSSS_CHK("err_clear", 1'b0, err)
   endtask
   task automatic t_config;
      `FSSS_CHK("reset_state", FSSS_POWER_ON, st)
      `FSSS_CHK("reset_mbx", 1'b0, ma)
      `FSSS_CHK("reset_pd", 1'b0, pa)
      req(FSSS_CONFIG);
      `FSSS_CHK("bad_mbx_err", 1'b1, err)
      `FSSS_CHK("bad_mbx_state", FSSS_POWER_ON, st)
      clear_err();
      i_m.setup(1, 0, 0);
      req(FSSS_CONFIG);
      `FSSS_CHK("cfg_ack", 1'b1, ack)
      `FSSS_CHK("cfg_state", FSSS_CONFIG, st)
      `FSSS_CHK("cfg_mbx", 1'b1, ma)
      `FSSS_CHK("cfg_pd_rej", 1'b1, pr)
      req(FSSS_RUNNING);
      `FSSS_CHK("skip_run", FSSS_CONFIG, st)
      `FSSS_CHK("skip_err", 1'b1, err)
      req(FSSS_FW_UPD);
      `FSSS_CHK("fw_from_cfg", FSSS_CONFIG, st)
      clear_err();
   endtask
   task automatic t_guarded;
      @(posedge clk) dc <= 1'b1;
      i_m.setup(1, 1, 0);
      i_m.send(8'ha5);
      req(FSSS_GUARDED);
      `FSSS_CHK("bad_clk", FSSS_CONFIG, st)
      i_m.setup(1, 1, 1);
      req(FSSS_GUARDED);
      `FSSS_CHK("grd_state", FSSS_GUARDED, st)
      `FSSS_CHK("grd_dpm", 8'h5a, dpm)
      `FSSS_CHK("grd_pd", 1'b1, pa)
      `FSSS_CHK("grd_safe", 8'h00, pout)
      @(posedge clk) pin_in <= 8'h3c;
      step(5);
      `FSSS_CHK("grd_refresh", 8'h3c, dpm)
      @(posedge clk) mon_en <= 1'b0;
      step(3);
      `FSSS_CHK("grd_nomon", 8'ha5, pout)
      @(posedge clk) mon_en <= 1'b1;
      step(3);
      `FSSS_CHK("grd_mon", 8'h00, pout)
   endtask
   task automatic t_running;
      i_m.send(8'hc3);
      req(FSSS_RUNNING);
      `FSSS_CHK("run_state", FSSS_RUNNING, st)
      step(2);
      `FSSS_CHK("run_out", 8'hc3, pout)
      `FSSS_CHK("run_mbx", 1'b1, ma)
      @(posedge clk) wtime <= 16'h0002;
      @(posedge clk) pd_acc <= 1'b0;
      step(2 * (0 + 2) * FSSS_BASE_CYC - 1);
      `FSSS_CHK("wdt_early", 1'b0, wexp)
      step(1);
      `FSSS_CHK("wdt_late", 1'b1, wexp)
      step(1);
      `FSSS_CHK("wdt_out", 8'h00, pout)
      `FSSS_CHK("wdt_state", FSSS_RUNNING, st)
      @(posedge clk) mult <= 16'h0001;
      pd_acc <= 1'b1;
      @(posedge clk) pd_acc <= 1'b0;
      step(2 * (1 + 2) * FSSS_BASE_CYC - 1);
      `FSSS_CHK("wdt_mult_early", 1'b0, wexp)
      step(1);
      `FSSS_CHK("wdt_mult_late", 1'b1, wexp)
      @(posedge clk) wtime <= 16'h0000;
      step(40);
      `FSSS_CHK("wdt_off", 1'b0, wexp)
   endtask
   task automatic t_boot;
      req(FSSS_POWER_ON);
      req(FSSS_FW_UPD);
      `FSSS_CHK("fw_state", FSSS_FW_UPD, st)
      @(posedge clk) mbx_file <= 1'b1;
      pd_acc <= 1'b1;
      step(1);
      `FSSS_CHK("fw_file", 1'b1, ma)
      `FSSS_CHK("fw_pd", 1'b1, pr)
      @(posedge clk) mbx_file <= 1'b0;
      step(1);
      `FSSS_CHK("fw_other", 1'b1, mr)
      @(posedge clk) rst_b <= 1'b0;
      step(2);
      `FSSS_CHK("rst_state", FSSS_POWER_ON, st)
      `FSSS_CHK("rst_err", 1'b0, err)
      `FSSS_CHK("rst_dpm", 8'h00, dpm)
      `FSSS_CHK("rst_mbx", 1'b0, ma)
      @(posedge clk) rst_b <= 1'b1;
      step(1);
      req(FSSS_CONFIG);
      `FSSS_CHK("rst_cfg", FSSS_CONFIG, st)
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      step(1);
      t_config();
      t_guarded();
      t_running();
      t_boot();
      report_and_stop();
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
